// [verilog/wpfb_regs.vh]
// Register offsets, field positions, reset values and CRC constants
// for the wake pattern filter bank. Definitions only.
`ifndef WPFB_REGS_VH
`define WPFB_REGS_VH

`define WPFB_NUM_FILT 8
`define WPFB_MASK_WORDS 32
// Word indices; byte address is four times the index
`define WPFB_IDX_MASK0 6'h00
`define WPFB_IDX_CMD0 6'h20
`define WPFB_IDX_CMD1 6'h21
`define WPFB_IDX_OFF0 6'h22
`define WPFB_IDX_OFF1 6'h23
`define WPFB_IDX_CRC0 6'h24
`define WPFB_IDX_CRC3 6'h27
`define WPFB_IDX_WCS 6'h28
`define WPFB_IDX_ISTAT 6'h29
`define WPFB_IDX_IMASK 6'h2A
`define WPFB_IDX_LAST 6'h2A
// Command fields
`define WPFB_CMD_EN 0
`define WPFB_CMD_AT_LO 2
`define WPFB_CMD_AT_HI 3
`define WPFB_AT_UNICAST 2'h0
`define WPFB_AT_MULTICAST 2'h2
// Wake control/status fields
`define WPFB_WCS_DET_EN 0
`define WPFB_WCS_GUNI_EN 9
// Reset values
`define WPFB_RST_WORD 32'h00000000
`define WPFB_RST_BYTE 8'h00
`define WPFB_RST_CRC 16'h0000
// CRC machine
`define WPFB_CRC_POLY 16'h8005
`define WPFB_CRC_INIT 16'hFFFF
`define WPFB_POS_MAX 11'h7FF

`endif

// [verilog/wpfb_top.v]
// Wake pattern filter bank: eight CRC-16 byte-mask filters with APB access.
// Assumes frame bytes arrive synchronous to clk_sys_i, destination address
// first, and frame class flags valid with the end-of-frame strobe.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`include "wpfb_regs.vh"

module wpfb_top (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire rx_byte_valid_i,
   input wire rx_sof_i,
   input wire [7:0] rx_byte_i,
   input wire rx_eof_i,
   input wire rx_broadcast_i,
   input wire rx_multicast_i,
   input wire rx_unicast_i,
   input wire rx_pass_filter_i,
   output wire wake_o,
   output wire [7:0] wake_match_o,
   output wire irq_o
);

   localparam ST_IDLE = 2'b01;
   localparam ST_ACCESS = 2'b10;

   reg [31:0] mask_r [0:31];
   reg [3:0] cmd_r [0:7];
   reg [7:0] off_r [0:7];
   reg [15:0] ref_r [0:7];
   reg [15:0] crc_r [0:7];
   reg [10:0] pos_r;
   reg [31:0] wcs_r;
   reg [7:0] istat_r;
   reg [7:0] imask_r;
   reg [1:0] state_r;
   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;
   reg wake_r;
   reg [7:0] wake_match_r;
   reg irq_r;

   reg [31:0] rdata_nxt;
   reg bad_nxt;
   reg [7:0] hit_nxt;
   reg [7:0] istat_nxt;
   reg [10:0] pos_cur;
   reg [10:0] rel;
   reg [15:0] crc_cur;
   reg [31:0] mword;
   reg [15:0] crc_nxt [0:7];
   integer f;
   integer k;
   integer fr;
   integer kw;
   integer fc;
   integer fw;

   wire [5:0] widx = paddr_i[7:2];
   wire done = psel_i & penable_i & pready_r;
   wire wr_done = done & pwrite_i & ~pslverr_r;
   wire rd_done = done & ~pwrite_i & ~pslverr_r;

   // Bit-serial CRC-16 over one byte, least significant bit first
   function [15:0] crc16_byte;
      input [15:0] crc;
      input [7:0] d;
      integer i;
      reg [15:0] c;
      begin
         c = crc;
         for (i = 0; i < 8; i = i + 1)
         begin
            if (c[15] ^ d[i])
               c = {c[14:0], 1'b0} ^ `WPFB_CRC_POLY;
            else
               c = {c[14:0], 1'b0};
         end
         crc16_byte = c;
      end
   endfunction

   // Command words come as a pair, filters 0..3 then 4..7
   function is_cmd_word;
      input [5:0] idx;
      begin
         is_cmd_word = (idx == `WPFB_IDX_CMD0) || (idx == `WPFB_IDX_CMD1);
      end
   endfunction

   // Offset words come as a pair, filters 0..3 then 4..7
   function is_off_word;
      input [5:0] idx;
      begin
         is_off_word = (idx == `WPFB_IDX_OFF0) || (idx == `WPFB_IDX_OFF1);
      end
   endfunction

   // Register readback and address decode
   always @*
   begin
      rdata_nxt = 32'h00000000;
      bad_nxt = 1'b0;
      if (paddr_i[11:8] != 4'h0 || widx > `WPFB_IDX_LAST)
         bad_nxt = 1'b1;
      else if (widx < `WPFB_IDX_CMD0)
         rdata_nxt = mask_r[widx[4:0]];
      else if (is_cmd_word(widx))
      begin
         for (k = 0; k < 4; k = k + 1)
            rdata_nxt[8*k +: 4] = cmd_r[{widx[0], k[1:0]}];
      end
      else if (is_off_word(widx))
      begin
         for (k = 0; k < 4; k = k + 1)
            rdata_nxt[8*k +: 8] = off_r[{widx[0], k[1:0]}];
      end
      else if (widx <= `WPFB_IDX_CRC3)
      begin
         rdata_nxt[15:0] = ref_r[{widx[1:0], 1'b0}];
         rdata_nxt[31:16] = ref_r[{widx[1:0], 1'b1}];
      end
      else if (widx == `WPFB_IDX_WCS)
         rdata_nxt = wcs_r;
      else if (widx == `WPFB_IDX_ISTAT)
         rdata_nxt = {24'h000000, istat_r};
      else
         rdata_nxt = {24'h000000, imask_r};
   end

   // End-of-frame wake decision per filter
   always @*
   begin
      hit_nxt = 8'h00;
      for (f = 0; f < `WPFB_NUM_FILT; f = f + 1)
      begin
         if (rx_eof_i && wcs_r[`WPFB_WCS_DET_EN] && cmd_r[f][`WPFB_CMD_EN]
            && crc_r[f] == ref_r[f])
         begin
            if (rx_broadcast_i)
               hit_nxt[f] = 1'b1;
            else if (rx_unicast_i && wcs_r[`WPFB_WCS_GUNI_EN])
               hit_nxt[f] = 1'b1;
            else if (rx_pass_filter_i)
            begin
               if (cmd_r[f][`WPFB_CMD_AT_LO])
                  hit_nxt[f] = 1'b1;
               else if (cmd_r[f][`WPFB_CMD_AT_HI:`WPFB_CMD_AT_LO] ==
                  `WPFB_AT_MULTICAST)
                  hit_nxt[f] = rx_multicast_i;
               else
                  hit_nxt[f] = rx_unicast_i;
            end
         end
      end
      // New events win over the read clear
      if (rd_done && widx == `WPFB_IDX_ISTAT)
         istat_nxt = hit_nxt;
      else
         istat_nxt = istat_r | hit_nxt;
   end

   // APB slave: setup cycle registers the answer, access completes at once
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ST_IDLE;
         prdata_r <= `WPFB_RST_WORD;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (psel_i && !penable_i)
               begin
                  state_r <= ST_ACCESS;
                  prdata_r <= pwrite_i ? 32'h00000000 : rdata_nxt;
                  pslverr_r <= bad_nxt;
                  pready_r <= 1'b1;
               end
            end
            ST_ACCESS:
            begin
               state_r <= ST_IDLE;
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
               prdata_r <= 32'h00000000;
            end
            default:
            begin
               state_r <= ST_IDLE;
               pready_r <= 1'b0;
            end
         endcase
      end
   end

   // Filter bank image and control registers
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (fr = 0; fr < `WPFB_MASK_WORDS; fr = fr + 1)
            mask_r[fr] <= `WPFB_RST_WORD;
         for (fr = 0; fr < `WPFB_NUM_FILT; fr = fr + 1)
         begin
            cmd_r[fr] <= 4'h0;
            off_r[fr] <= `WPFB_RST_BYTE;
            ref_r[fr] <= `WPFB_RST_CRC;
         end
         wcs_r <= `WPFB_RST_WORD;
         imask_r <= 8'h00;
      end
      else if (wr_done)
      begin
         if (widx < `WPFB_IDX_CMD0)
            mask_r[widx[4:0]] <= pwdata_i;
         else if (is_cmd_word(widx))
         begin
            // Reserved bit 1 is not stored, so it reads back zero
            for (kw = 0; kw < 4; kw = kw + 1)
               cmd_r[{widx[0], kw[1:0]}] <= {pwdata_i[8*kw+2 +: 2], 1'b0,
                  pwdata_i[8*kw]};
         end
         else if (is_off_word(widx))
         begin
            for (kw = 0; kw < 4; kw = kw + 1)
               off_r[{widx[0], kw[1:0]}] <= pwdata_i[8*kw +: 8];
         end
         else if (widx <= `WPFB_IDX_CRC3)
         begin
            ref_r[{widx[1:0], 1'b0}] <= pwdata_i[15:0];
            ref_r[{widx[1:0], 1'b1}] <= pwdata_i[31:16];
         end
         else if (widx == `WPFB_IDX_WCS)
         begin
            wcs_r[`WPFB_WCS_DET_EN] <= pwdata_i[`WPFB_WCS_DET_EN];
            wcs_r[`WPFB_WCS_GUNI_EN] <= pwdata_i[`WPFB_WCS_GUNI_EN];
         end
         else if (widx == `WPFB_IDX_IMASK)
            imask_r <= pwdata_i[7:0];
      end
   end

   // Byte position and per-filter CRC machines
   always @*
   begin
      pos_cur = rx_sof_i ? 11'h000 : pos_r;
   end

   // Mask word read here, not in a function, so the sensitivity list sees it
   always @*
   begin
      rel = 11'h000;
      crc_cur = `WPFB_CRC_INIT;
      mword = 32'h00000000;
      for (fw = 0; fw < `WPFB_NUM_FILT; fw = fw + 1)
      begin
         rel = pos_cur - {3'h0, off_r[fw]};
         crc_cur = rx_sof_i ? `WPFB_CRC_INIT : crc_r[fw];
         mword = mask_r[{fw[2:0], rel[6:5]}];
         if (pos_cur >= {3'h0, off_r[fw]} && rel < 11'h080 && mword[rel[4:0]])
            crc_nxt[fw] = crc16_byte(crc_cur, rx_byte_i);
         else
            crc_nxt[fw] = crc_cur;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pos_r <= 11'h000;
         for (fc = 0; fc < `WPFB_NUM_FILT; fc = fc + 1)
            crc_r[fc] <= `WPFB_CRC_INIT;
      end
      else if (rx_byte_valid_i)
      begin
         // Position saturates; long frames cannot wrap into the mask range
         if (pos_cur != `WPFB_POS_MAX)
            pos_r <= pos_cur + 11'h001;
         for (fc = 0; fc < `WPFB_NUM_FILT; fc = fc + 1)
            crc_r[fc] <= crc_nxt[fc];
      end
      else if (rx_sof_i)
      begin
         pos_r <= 11'h000;
         for (fc = 0; fc < `WPFB_NUM_FILT; fc = fc + 1)
            crc_r[fc] <= `WPFB_CRC_INIT;
      end
   end

   // Wake events, sticky status and interrupt
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wake_r <= 1'b0;
         wake_match_r <= 8'h00;
         istat_r <= 8'h00;
         irq_r <= 1'b0;
      end
      else
      begin
         wake_r <= |hit_nxt;
         wake_match_r <= hit_nxt;
         istat_r <= istat_nxt;
         irq_r <= |(istat_nxt & imask_r);
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign wake_o = wake_r;
   assign wake_match_o = wake_match_r;
   assign irq_o = irq_r;

endmodule // wpfb_top

// [tb/wpfb_checker.sv]
// Port checker for the wake pattern filter bank
// Bound to wpfb_top; sees only its ports
`timescale 1ns/1ps
module wpfb_checker (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire [11:0] paddr_i,
   input wire pready_o,
   input wire pslverr_o,
   input wire rx_eof_i,
   input wire wake_o,
   input wire [7:0] wake_match_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("ready missing");
   ready_single_a: assert property (pready_o |=> !pready_o)
      else $error("ready too long");
   err_with_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   unmapped_error_a: assert property (psel_i && !penable_i && paddr_i[11:2] > 10'h02A
      |=> pslverr_o) else $error("no error on unmapped");
   mapped_no_error_a: assert property (psel_i && !penable_i && paddr_i[11:2] <= 10'h02A
      |=> !pslverr_o) else $error("error on mapped");
   wake_after_eof_a: assert property (wake_o |-> $past(rx_eof_i))
      else $error("wake not after frame end");
   wake_any_match_a: assert property (wake_o == (wake_match_o != 8'h00))
      else $error("wake and match disagree");
   wake_single_a: assert property (wake_o |=> !wake_o)
      else $error("wake too long");
endmodule // wpfb_checker

// [tb/wpfb_mac_model.sv]
// MAC receive path model: one 40-byte frame per send call
// Assumes the caller enters send just after a clock edge
`timescale 1ns/1ps
module wpfb_mac_model (
   input wire clk_sys_i,
   output reg rx_byte_valid_o = 1'b0,
   output reg rx_sof_o = 1'b0,
   output reg [7:0] rx_byte_o = 8'h00,
   output reg rx_eof_o = 1'b0,
   output reg [3:0] rx_class_o = 4'h0
);
   // Byte p is p*7 plus seed; class is pass, unicast, multicast, broadcast
   task send(input [3:0] cls, input [7:0] seed);
      integer p;
      begin
         for (p = 0; p < 40; p = p + 1)
         begin
            @(posedge clk_sys_i);
            rx_byte_valid_o <= 1'b1;
            rx_sof_o <= (p == 0);
            rx_byte_o <= seed + p[7:0] * 8'h07;
         end
         @(posedge clk_sys_i);
         rx_byte_valid_o <= 1'b0;
         rx_sof_o <= 1'b0;
         // Stale data inverted so it never looks valid
         rx_byte_o <= ~rx_byte_o;
         rx_eof_o <= 1'b1;
         rx_class_o <= cls;
         @(posedge clk_sys_i);
         rx_eof_o <= 1'b0;
         rx_class_o <= ~cls;
      end
   endtask
endmodule // wpfb_mac_model

// [tb/wpfb_top_tb.sv]
// Bench for the wake pattern filter bank: APB programming and frames
// Assumes the MAC model drives frames; checker bound at the foot
`timescale 1ns/1ps
`include "wpfb_regs.vh"
module wpfb_top_tb;
   reg clk_sys_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   reg [11:0] paddr_i = 12'h000;
   reg [31:0] pwdata_i = 32'h0;
   wire [31:0] prdata_o;
   wire [7:0] wake_match_o, rx_byte_i;
   wire pready_o, pslverr_o, wake_o, irq_o, rx_byte_valid_i, rx_sof_i, rx_eof_i;
   wire rx_broadcast_i, rx_multicast_i, rx_unicast_i, rx_pass_filter_i;
   integer miscompares = 0, cmp_count = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   wpfb_top wpfb_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .rx_byte_valid_i(rx_byte_valid_i), .rx_sof_i(rx_sof_i), .rx_byte_i(rx_byte_i),
      .rx_eof_i(rx_eof_i), .rx_broadcast_i(rx_broadcast_i), .rx_multicast_i(rx_multicast_i),
      .rx_unicast_i(rx_unicast_i), .rx_pass_filter_i(rx_pass_filter_i), .wake_o(wake_o),
      .wake_match_o(wake_match_o), .irq_o(irq_o));
   wpfb_mac_model wpfb_mac_model_i (
      .clk_sys_i(clk_sys_i),
      .rx_byte_valid_o(rx_byte_valid_i),
      .rx_sof_o(rx_sof_i),
      .rx_byte_o(rx_byte_i),
      .rx_eof_o(rx_eof_i),
      .rx_class_o({rx_pass_filter_i, rx_unicast_i, rx_multicast_i, rx_broadcast_i})
   );
   task check(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         miscompares = miscompares + (seen !== exp);
         if (seen !== exp)
            $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Reads pass the expected value in d
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_sys_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_sys_i);
         penable_i <= 1'b1;
         // Answer taken at the edge that ends the access phase
         @(posedge clk_sys_i);
         while (pready_o !== 1'b1)
            @(posedge clk_sys_i);
         if (!w)
            check(prdata_o, d);
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   // Reference CRC over the masked bytes of a seed 1 frame
   function [15:0] crc(input [127:0] m, input [7:0] off);
      integer p, k;
      begin
         crc = `WPFB_CRC_INIT;
         for (p = 0; p < 40; p = p + 1)
            for (k = 0; k < 8; k = k + 1)
               if (p >= off && m[p - off])
                  crc = {crc[14:0], 1'b0} ^
                     (((crc[15] ^ ((p * 7 + 1) >> k)) & 1) ? `WPFB_CRC_POLY : 16'h0);
      end
   endfunction
   task frame(input [3:0] c, input [7:0] s, input [7:0] e);
      begin
         wpfb_mac_model_i.send(c, s);
         #1;
         check(wake_match_o, e);
      end
   endtask
   task summarize(input integer bad);
      begin
         miscompares = miscompares + bad;
         $display("compares %0d miscompares %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Tests need under a thousand cycles
   initial #50000 summarize(1);
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 12'h080, 32'h0);
      apb(1'b0, 12'h0B0, 32'h0);
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h010, 32'hFF);
      apb(1'b1, 12'h088, 32'h502);
      apb(1'b1, 12'h090, {crc(128'hFF, 8'h05), crc({96'h1, 32'h3}, 8'h02)});
      apb(1'b1, 12'h080, 32'h105);
      apb(1'b1, 12'h0A8, 32'hFF);
      apb(1'b1, 12'h0A0, 32'h1);
      apb(1'b0, 12'h004, 32'h1);
      apb(1'b0, 12'h088, 32'h502);
      apb(1'b0, 12'h090, {crc(128'hFF, 8'h05), crc({96'h1, 32'h3}, 8'h02)});
      frame(4'hC, 8'h01, 8'h03);
      check(irq_o, 1'b1);
      frame(4'hA, 8'h01, 8'h01);
      frame(4'hC, 8'h02, 8'h00);
      frame(4'h4, 8'h01, 8'h00);
      frame(4'h1, 8'h01, 8'h03);
      apb(1'b1, 12'h0A0, 32'h201);
      frame(4'h4, 8'h01, 8'h03);
      apb(1'b0, 12'h0A4, 32'h3);
      apb(1'b0, 12'h0A4, 32'h0);
      apb(1'b1, 12'h0A8, 32'h0);
      check(irq_o, 1'b0);
      apb(1'b1, 12'h080, 32'h106);
      apb(1'b0, 12'h080, 32'h104);
      frame(4'hC, 8'h01, 8'h02);
      check(irq_o, 1'b0);
      apb(1'b1, 12'h080, 32'h906);
      frame(4'hA, 8'h01, 8'h02);
      frame(4'h2, 8'h01, 8'h00);
      apb(1'b1, 12'h0A0, 32'h0);
      frame(4'hC, 8'h01, 8'h00);
      summarize(0);
   end
endmodule // wpfb_top_tb
bind wpfb_top wpfb_checker wpfb_checker_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .rx_eof_i(rx_eof_i), .wake_o(wake_o), .wake_match_o(wake_match_o));
